// ==== hw/jtag_dbg_consts.vh ====
`ifndef JTAG_DBG_CONSTS_VH
`define JTAG_DBG_CONSTS_VH

// instruction codes
`define IR_WIDTH 5
`define IR_IDCODE 5'h01
`define IR_XPORT_CTRL 5'h10
`define IR_DBG_SCAN 5'h11
`define IR_SKIP 5'h1f

// scan register layout
`define SCAN_WIDTH 41
`define SCAN_ADDR_HI 40
`define SCAN_ADDR_LO 34
`define SCAN_DATA_HI 33
`define SCAN_DATA_LO 2
`define SCAN_OP_HI 1
`define SCAN_OP_LO 0
`define ADDR_BITS 7

// operation codes
`define OP_NOP 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2
`define OP_OK 2'h0

// transport control fields
`define XPORT_ABITS_LO 4
`define XPORT_VERSION 4'h1

// debug module offsets
`define DM_DATA_LO 7'h04
`define DM_DATA_HI 7'h05
`define DM_CONTROL 7'h10
`define DM_STATUS 7'h11
`define DM_ABS_CS 7'h16
`define DM_ABS_CMD 7'h17
`define DM_AUTORUN 7'h18
`define DM_SB_CS 7'h38
`define DM_SB_ADDR 7'h39
`define DM_SB_WLO 7'h3c
`define DM_SB_WHI 7'h3d
`define DM_HALTSUM 7'h40

// control register bits
`define CTL_HALT_REQ 31
`define CTL_RESUME_REQ 30
`define CTL_HART_RESET 29
`define CTL_ACK_RESET 28
`define CTL_ACTIVE 0

// status register bits
`define STS_VERSION 4'h2
`define STS_ANY_HALTED 8
`define STS_ANY_RUNNING 10
`define STS_ANY_RESUMEACK 16
`define STS_ANY_HAVERESET 18

`endif

// ==== hw/jtag_debug_access.v ====
`timescale 1ns/1ns
`include "jtag_dbg_consts.vh"

module jtag_debug_access #(
  parameter [31:0] id_code = 32'h00000001 // arbitrary identity value
) (
  // core clock and reset
  input wire clk,
  input wire nrst,
  // test access pins
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire ntrst,
  output reg tdo,
  output reg tdo_oe,
  // hart handshake
  input wire hart_halted,
  input wire hart_running,
  input wire hart_was_reset,
  input wire abs_cmd_busy,
  output reg halt_request,
  output reg resume_pulse,
  output reg hart_reset_out,
  output reg abs_cmd_go,
  output reg [31:0] abs_cmd_word
);

  // tap states
  localparam [3:0] st_reset = 4'h0;
  localparam [3:0] st_idle = 4'h1;
  localparam [3:0] st_sel_dr = 4'h2;
  localparam [3:0] st_cap_dr = 4'h3;
  localparam [3:0] st_sh_dr = 4'h4;
  localparam [3:0] st_ex1_dr = 4'h5;
  localparam [3:0] st_pa_dr = 4'h6;
  localparam [3:0] st_ex2_dr = 4'h7;
  localparam [3:0] st_up_dr = 4'h8;
  localparam [3:0] st_sel_ir = 4'h9;
  localparam [3:0] st_cap_ir = 4'ha;
  localparam [3:0] st_sh_ir = 4'hb;
  localparam [3:0] st_ex1_ir = 4'hc;
  localparam [3:0] st_pa_ir = 4'hd;
  localparam [3:0] st_ex2_ir = 4'he;
  localparam [3:0] st_up_ir = 4'hf;

  // synchronise pins; first stage is read only by second
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg tck_prev;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      tck_prev <= 1'b0;
    end else begin
      pin_s1 <= {ntrst, tdi, tms, tck};
      pin_s2 <= pin_s1;
      tck_prev <= pin_s2[0];
    end
  end
  wire tck_s = pin_s2[0];
  wire tms_s = pin_s2[1];
  wire tdi_s = pin_s2[2];
  wire ntrst_s = pin_s2[3];
  // rising edge drives state/shift, falling drives tdo; needs clk >= 2x tck
  wire tck_rise = tck_s & ~tck_prev;
  wire tck_fall = ~tck_s & tck_prev;

  // tap state transition
  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        st_reset: tap_next = m ? st_reset : st_idle;
        st_idle: tap_next = m ? st_sel_dr : st_idle;
        st_sel_dr: tap_next = m ? st_sel_ir : st_cap_dr;
        st_cap_dr: tap_next = m ? st_ex1_dr : st_sh_dr;
        st_sh_dr: tap_next = m ? st_ex1_dr : st_sh_dr;
        st_ex1_dr: tap_next = m ? st_up_dr : st_pa_dr;
        st_pa_dr: tap_next = m ? st_ex2_dr : st_pa_dr;
        st_ex2_dr: tap_next = m ? st_up_dr : st_sh_dr;
        st_up_dr: tap_next = m ? st_sel_dr : st_idle;
        st_sel_ir: tap_next = m ? st_reset : st_cap_ir;
        st_cap_ir: tap_next = m ? st_ex1_ir : st_sh_ir;
        st_sh_ir: tap_next = m ? st_ex1_ir : st_sh_ir;
        st_ex1_ir: tap_next = m ? st_up_ir : st_pa_ir;
        st_pa_ir: tap_next = m ? st_ex2_ir : st_pa_ir;
        st_ex2_ir: tap_next = m ? st_up_ir : st_sh_ir;
        st_up_ir: tap_next = m ? st_sel_dr : st_idle;
        default: tap_next = st_reset;
      endcase
    end
  endfunction

  reg [3:0] tap_state;
  reg [`IR_WIDTH-1:0] ir_shift;
  reg [`IR_WIDTH-1:0] ir;
  reg [`SCAN_WIDTH-1:0] dr_shift;
  reg [31:0] read_result;
  reg launch;
  reg [`ADDR_BITS-1:0] launch_addr;
  reg [31:0] launch_data;
  reg [1:0] launch_op;

  wire [3:0] next_state = tap_next(tap_state, tms_s);
  wire sel_scan = (ir == `IR_DBG_SCAN);
  wire sel_id = (ir == `IR_IDCODE);
  wire sel_xport = (ir == `IR_XPORT_CTRL);
  // any other code falls to the skip cell
  wire sel_skip = ~sel_scan & ~sel_id & ~sel_xport;

  // transport control word: address width and version, rest zero
  wire [31:0] xport_word = {22'h0, 6'd`ADDR_BITS, `XPORT_VERSION};

  // tap controller, instruction and data scan chains
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tap_state <= st_reset;
      ir_shift <= 5'h00;
      ir <= `IR_IDCODE;
      dr_shift <= 41'h0;
      launch <= 1'b0;
      launch_addr <= 7'h00;
      launch_data <= 32'h0;
      launch_op <= `OP_NOP;
    end else begin
      launch <= 1'b0;
      if (!ntrst_s) begin
        tap_state <= st_reset;
        ir <= `IR_IDCODE;
      end else if (tck_rise) begin
        tap_state <= next_state;
        case (tap_state)
          st_reset: ir <= `IR_IDCODE;
          st_cap_ir: ir_shift <= 5'h01;
          st_sh_ir: ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
          st_up_ir: ir <= ir_shift;
          st_cap_dr: begin
            if (sel_scan)
              dr_shift <= {launch_addr, read_result, `OP_OK};
            else if (sel_id)
              dr_shift <= {9'h0, id_code};
            else if (sel_xport)
              dr_shift <= {9'h0, xport_word};
            else
              dr_shift <= 41'h0;
          end
          st_sh_dr: begin
            if (sel_scan)
              dr_shift <= {tdi_s, dr_shift[`SCAN_WIDTH-1:1]};
            else if (sel_skip)
              dr_shift <= {40'h0, tdi_s};
            else
              dr_shift <= {9'h0, tdi_s, dr_shift[31:1]};
          end
          st_up_dr: begin
            if (sel_scan) begin
              launch <= 1'b1;
              launch_addr <= dr_shift[`SCAN_ADDR_HI:`SCAN_ADDR_LO];
              launch_data <= dr_shift[`SCAN_DATA_HI:`SCAN_DATA_LO];
              launch_op <= dr_shift[`SCAN_OP_HI:`SCAN_OP_LO];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // tdo changes on falling test clock, driven only while shifting
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (tap_state == st_sh_dr) | (tap_state == st_sh_ir);
      tdo <= (tap_state == st_sh_ir) ? ir_shift[0] : dr_shift[0];
    end
  end

  // debug module registers, base zero so address is offset
  reg [31:0] data_lo;
  reg [31:0] data_hi;
  reg [31:0] autorun;
  reg [31:0] sb_cs;
  reg [31:0] sb_addr;
  reg [31:0] sb_wlo;
  reg [31:0] sb_whi;
  reg dm_active;
  reg resume_ack;
  reg have_reset;
  reg cmd_error;

  wire do_write = launch & (launch_op == `OP_WRITE);
  wire do_read = launch & (launch_op == `OP_READ);
  wire ctl_wr = do_write & (launch_addr == `DM_CONTROL);
  // resume honoured only with no halt request in the same write
  wire resume_ok = ctl_wr & launch_data[`CTL_RESUME_REQ]
    & ~launch_data[`CTL_HALT_REQ] & hart_halted;

  // status: version, halted/running, resume ack and reset flags doubled
  wire [31:0] status_word = {12'h0, have_reset, have_reset, resume_ack, resume_ack,
    4'h0, hart_running, hart_running, hart_halted, hart_halted, 4'h0, `STS_VERSION};
  wire [31:0] abs_cs_word = {21'h0, abs_cmd_busy, 1'b0, cmd_error, 8'h2};

  // register read mux; halt, resume and ack bits read 0, hart reset reads back at bit 1
  function [31:0] dm_read;
    input [`ADDR_BITS-1:0] a;
    begin
      case (a)
        `DM_DATA_LO: dm_read = data_lo;
        `DM_DATA_HI: dm_read = data_hi;
        `DM_CONTROL: dm_read = {30'h0, hart_reset_out, dm_active};
        `DM_STATUS: dm_read = status_word;
        `DM_ABS_CS: dm_read = abs_cs_word;
        `DM_AUTORUN: dm_read = autorun;
        `DM_SB_CS: dm_read = sb_cs;
        `DM_SB_ADDR: dm_read = sb_addr;
        `DM_SB_WLO: dm_read = sb_wlo;
        `DM_SB_WHI: dm_read = sb_whi;
        `DM_HALTSUM: dm_read = {31'h0, hart_halted};
        default: dm_read = 32'h0;
      endcase
    end
  endfunction

  // register writes; unlisted offsets fall through silently
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_lo <= 32'h0;
      data_hi <= 32'h0;
      autorun <= 32'h0;
      sb_cs <= 32'h0;
      sb_addr <= 32'h0;
      sb_wlo <= 32'h0;
      sb_whi <= 32'h0;
      dm_active <= 1'b0;
      halt_request <= 1'b0;
      hart_reset_out <= 1'b0;
      abs_cmd_word <= 32'h0;
      read_result <= 32'h0;
      cmd_error <= 1'b0;
    end else begin
      if (do_read)
        read_result <= dm_read(launch_addr);
      if (do_write) begin
        case (launch_addr)
          `DM_DATA_LO: data_lo <= launch_data;
          `DM_DATA_HI: data_hi <= launch_data;
          `DM_AUTORUN: autorun <= launch_data;
          // system bus path usable whether hart runs or not
          `DM_SB_CS: sb_cs <= launch_data;
          `DM_SB_ADDR: sb_addr <= launch_data;
          `DM_SB_WLO: sb_wlo <= launch_data;
          `DM_SB_WHI: sb_whi <= launch_data;
          `DM_ABS_CMD: abs_cmd_word <= launch_data;
          `DM_CONTROL: begin
            dm_active <= launch_data[`CTL_ACTIVE];
            hart_reset_out <= launch_data[1];
            halt_request <= launch_data[`CTL_HALT_REQ];
          end
          default: ;
        endcase
      end
      // command refused unless hart sits in debug halted state
      if (do_write & (launch_addr == `DM_ABS_CMD) & ~hart_halted)
        cmd_error <= 1'b1;
      else if (do_write & (launch_addr == `DM_ABS_CS) & launch_data[8])
        cmd_error <= 1'b0;
    end
  end

  // command launch, hart pulses and the sticky resume ack and reset flags
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      abs_cmd_go <= 1'b0;
      resume_pulse <= 1'b0;
      resume_ack <= 1'b0;
      have_reset <= 1'b1;
    end else begin
      abs_cmd_go <= do_write & (launch_addr == `DM_ABS_CMD) & hart_halted;
      resume_pulse <= resume_ok;
      // set wins over clear for both sticky flags
      if (hart_running & ~hart_halted & ~resume_pulse)
        resume_ack <= 1'b1;
      else if (resume_ok)
        resume_ack <= 1'b0;
      if (hart_was_reset)
        have_reset <= 1'b1;
      else if (ctl_wr & launch_data[`CTL_ACK_RESET])
        have_reset <= 1'b0;
    end
  end

endmodule

// ==== testbench/jtag_debug_access_properties.sv ====
`timescale 1ns/1ns
module jtag_debug_access_properties (
  // clock and reset
  input wire clk,
  input wire nrst,
  // pins and hart side
  input wire tck,
  input wire tdo,
  input wire tdo_oe,
  input wire hart_halted,
  input wire halt_request,
  input wire resume_pulse,
  input wire abs_cmd_go,
  input wire [31:0] abs_cmd_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // resume only reaches a halted hart
  property p_res_halt; resume_pulse |-> hart_halted; endproperty
  a_res_halt: assert property (p_res_halt) else $error("resume when not halted");
  property p_res_hreq; resume_pulse |-> !halt_request; endproperty
  a_res_hreq: assert property (p_res_hreq) else $error("resume under halt");
  property p_res_one; resume_pulse |=> !resume_pulse; endproperty
  a_res_one: assert property (p_res_one) else $error("resume too long");
  // commands need a halted hart
  property p_go_halt; abs_cmd_go |-> hart_halted; endproperty
  a_go_halt: assert property (p_go_halt) else $error("go while running");
  property p_go_one; abs_cmd_go |=> !abs_cmd_go; endproperty
  a_go_one: assert property (p_go_one) else $error("go too long");
  // register effects follow update, which is seen while tck is high
  property p_halt_upd; $changed(halt_request) |-> tck; endproperty
  a_halt_upd: assert property (p_halt_upd) else $error("halt off update");
  property p_cmd_upd; $changed(abs_cmd_word) |-> tck; endproperty
  a_cmd_upd: assert property (p_cmd_upd) else $error("command off update");
  // shift output moves only in the low half of tck
  property p_tdo_fall; $changed(tdo) |-> !tck; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off fall");
  property p_oe_fall; $changed(tdo_oe) |-> !tck; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("enable off fall");
endmodule

// ==== testbench/jtag_probe_model.sv ====
`timescale 1ns/1ns
module jtag_probe_model (
  // core clock paces the probe
  input wire clk,
  input wire tdo,
  // test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  // finished scan for the bench
  output logic [40:0] cap,
  output logic cap_v
);
  // tck stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    cap = '0;
    cap_v = 1'b0;
  end
  // one 160 ns period, tdo taken just before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (20) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (20) @(posedge clk);
    tck <= 1'b0;
  endtask
  // whole scan; idle ticks flip tdi so stale bits never pass
  task automatic scan(input bit ir, input int n, input logic [40:0] din, input bit chk);
    logic b;
    logic [40:0] q;
    q = '0;
    tick(1'b1, ~tdi, b);
    if (ir) tick(1'b1, ~tdi, b);
    tick(1'b0, ~tdi, b);
    tick(1'b0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      q[i] = b;
    end
    tick(1'b1, ~tdi, b);
    tick(1'b0, ~tdi, b);
    if (chk) begin
      cap <= q;
      cap_v <= 1'b1;
      @(posedge clk);
      cap_v <= 1'b0;
    end
  endtask
  task automatic reset_tap();
    logic b;
    repeat (5) tick(1'b1, ~tdi, b);
    tick(1'b0, ~tdi, b);
  endtask
endmodule

// ==== testbench/jtag_debug_access_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module jtag_debug_access_tb_top;
  logic clk;
  logic nrst;
  logic ntrst;
  logic hart_halted;
  logic hart_was_reset;
  logic abs_cmd_busy;
  logic [31:0] seed = 32'h30;
  logic [40:0] exp_scan;
  logic [40:0] expq[$];
  int failures = 0;
  int comparisons = 0;
  wire tck, tms, tdi, tdo, tdo_oe, cap_v, halt_request, resume_pulse, abs_cmd_go;
  wire [40:0] cap;
  wire [31:0] abs_cmd_word;
  wire hart_running = !hart_halted;
  jtag_debug_access dut (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
    .ntrst(ntrst), .tdo(tdo), .tdo_oe(tdo_oe), .hart_halted(hart_halted),
    .hart_running(hart_running), .hart_was_reset(hart_was_reset),
    .abs_cmd_busy(abs_cmd_busy), .halt_request(halt_request), .resume_pulse(resume_pulse),
    .hart_reset_out(), .abs_cmd_go(abs_cmd_go), .abs_cmd_word(abs_cmd_word));
  jtag_probe_model prb (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .cap(cap), .cap_v(cap_v));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hart halts on request, runs again on resume
  always @(posedge clk or negedge nrst) begin
    if (!nrst) hart_halted <= 1'b0;
    else if (halt_request) hart_halted <= 1'b1;
    else if (resume_pulse) hart_halted <= 1'b0;
  end
  // oldest note meets each finished scan
  always @(posedge clk) begin
    if (cap_v === 1'b1) begin
      exp_scan = expq.pop_front();
      `CHK(cap, exp_scan)
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // every ir capture reads back 0x01
  task automatic ir(input logic [4:0] c);
    expq.push_back(41'h1);
    prb.scan(1'b1, 5, {36'h0, c}, 1'b1);
  endtask
  task automatic dmi(input logic [6:0] a, input logic [31:0] d, input logic [1:0] op,
      input bit chk, input logic [40:0] e);
    if (chk) expq.push_back(e);
    prb.scan(1'b0, 41, {a, d, op}, chk);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic [4:0] c;
    nrst = 1'b0;
    ntrst = 1'b0;
    hart_was_reset = 1'b0;
    abs_cmd_busy = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    ntrst <= 1'b1;
    repeat (4) @(posedge clk);
    prb.reset_tap();
    ir(5'h10);
    expq.push_back(41'h71);
    prb.scan(1'b0, 32, 41'h0, 1'b1);
    `CHK(tdo_oe, 1'b0)
    // skip cell: 0x1f, then random unused codes, one bit of delay
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      c = (i == 0) ? 5'h1f : v[4:0];
      if (c == 5'h01 || c == 5'h10 || c == 5'h11) c = 5'h00;
      ir(c);
      v = rnd();
      expq.push_back({33'h0, v[6:0], 1'b0});
      prb.scan(1'b0, 8, {33'h0, v[7:0]}, 1'b1);
    end
    ir(5'h11);
    v = rnd();
    w = rnd();
    dmi(7'h04, v, 2'h2, 1'b0, 41'h0);
    dmi(7'h05, w, 2'h2, 1'b0, 41'h0);
    dmi(7'h04, ~v, 2'h3, 1'b0, 41'h0);
    dmi(7'h07, v, 2'h2, 1'b0, 41'h0);
    dmi(7'h04, 32'h0, 2'h1, 1'b0, 41'h0);
    dmi(7'h05, 32'h0, 2'h1, 1'b1, {7'h04, v, 2'h0});
    dmi(7'h07, 32'h0, 2'h1, 1'b1, {7'h05, w, 2'h0});
    dmi(7'h10, 32'h80000001, 2'h2, 1'b1, {7'h07, 32'h0, 2'h0});
    `CHK(halt_request, 1'b1)
    dmi(7'h10, 32'hc0000001, 2'h2, 1'b0, 41'h0);
    `CHK(hart_halted, 1'b1)
    dmi(7'h10, 32'h0, 2'h1, 1'b0, 41'h0);
    dmi(7'h17, v, 2'h2, 1'b1, {7'h10, 32'h1, 2'h0});
    `CHK(abs_cmd_word, v)
    dmi(7'h10, 32'h40000001, 2'h2, 1'b0, 41'h0);
    `CHK(hart_halted, 1'b0)
    dmi(7'h17, w, 2'h2, 1'b0, 41'h0);
    // status before and after acknowledging reset, then the refused command
    dmi(7'h11, 32'h0, 2'h1, 1'b0, 41'h0);
    dmi(7'h10, 32'h10000001, 2'h2, 1'b1, {7'h11, 32'h000f0c02, 2'h0});
    dmi(7'h11, 32'h0, 2'h1, 1'b0, 41'h0);
    dmi(7'h16, 32'h0, 2'h1, 1'b1, {7'h11, 32'h00030c02, 2'h0});
    dmi(7'h40, 32'h0, 2'h1, 1'b1, {7'h16, 32'h00000102, 2'h0});
    dmi(7'h00, 32'h0, 2'h0, 1'b1, {7'h40, 32'h0, 2'h0});
    print_verdict();
  end
endmodule
bind jtag_debug_access jtag_debug_access_properties u_props (.clk(clk), .nrst(nrst),
  .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .hart_halted(hart_halted),
  .halt_request(halt_request), .resume_pulse(resume_pulse), .abs_cmd_go(abs_cmd_go),
  .abs_cmd_word(abs_cmd_word));
